// *** rtl/slpm_monitor.sv ***
// Limited position monitor: two limit pairs, violation stop, status words.
// Assumes all inputs are synchronous to core_clk; referencing, direction
// monitor and stop execution live outside and meet us through ports.
`timescale 1ns/1ps
`include "slpm_consts.svh"
module slpm_monitor
	import slpm_pkg::*;
#(
	parameter int POS_W = `SLPM_POS_W
) (
	input  wire logic                    core_clk,
	input  wire logic                    rst_n,
	input  wire logic                    power_on_pulse,
	input  wire logic [31:0]             safety_enable_word,
	input  wire slpm_pair_t              upper_limit_pair,
	input  wire slpm_pair_t              lower_limit_pair,
	input  wire logic [7:0]              limit_stop_response,
	input  wire logic [15:0]             bus_failure_delay,
	input  wire logic                    use_terminals,
	input  wire logic                    short_telegram,
	input  wire logic [31:0]             safety_control_word_one,
	input  wire logic [31:0]             safety_control_word_two,
	input  wire logic                    failsafe_input_select,
	input  wire logic                    failsafe_input_range,
	input  wire logic                    failsafe_input_retract,
	input  wire logic                    safe_ack,
	input  wire logic                    comm_lost,
	input  wire logic                    safely_referenced,
	input  wire logic signed [POS_W-1:0] position,
	output logic [31:0]                  control_diag_bits_ff,
	output logic [31:0]                  status_diag_bits_ff,
	output logic [31:0]                  safety_status_word_one_ff,
	output logic [31:0]                  safety_status_word_two_ff,
	output logic                         failsafe_output_active_ff,
	output logic                         failsafe_output_area_ff,
	output logic                         stop_request_ff,
	output logic [7:0]                   stop_code_ff,
	output logic                         extended_stop_retract_ff,
	output logic                         limit_violation_message_ff,
	output logic                         config_conflict_fault_ff,
	output logic                         dir_monitor_pos_ff,
	output logic                         dir_monitor_neg_ff
);
	slpm_state_t state_ff;       // Monitor state
	slpm_state_t nxt_state;
	logic        enabled_ff;     // Enable latched at power-on
	logic        retract_q_ff;   // Retract input, previous cycle
	logic        viol_low_ff;    // Lower limit was the one passed
	logic        viol_low_next;
	slpm_kept_t  kept_r1;        // Compare results, range one
	slpm_kept_t  kept_r2;        // Compare results, range two
	slpm_kept_t  kept_act;       // Results of the selected range
	logic        sel_fn;         // Function selected
	logic        sel_range;      // Range two selected
	logic        active;         // Internal active diagnostic
	logic        violated_now;   // Selected range breached
	logic        retract_rise;
	logic        retract_fall;

	// One comparator per range; the pairs are split into ranges here
	slpm_limit_cmp #(.POS_W(POS_W)) u_cmp_r1 (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.position (position),
		.pair     ('{upper: upper_limit_pair.upper,
		             lower: lower_limit_pair.upper}),
		.kept_ff  (kept_r1)
	);
	slpm_limit_cmp #(.POS_W(POS_W)) u_cmp_r2 (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.position (position),
		.pair     ('{upper: upper_limit_pair.lower,
		             lower: lower_limit_pair.lower}),
		.kept_ff  (kept_r2)
	);

	// Selection source: terminals or the two control words
	always_comb begin
		if (use_terminals) begin
			sel_fn    = failsafe_input_select;
			sel_range = failsafe_input_range;
		end else begin
			sel_fn    = safety_control_word_one[`SLPM_CW_SEL_BIT] |
			            safety_control_word_two[`SLPM_CW_SEL_BIT];
			// Short telegram never reaches range two
			sel_range = !short_telegram &
			            safety_control_word_two[`SLPM_CW_RANGE_BIT];
		end
		sel_fn       = sel_fn & enabled_ff & !config_conflict_fault_ff;
		kept_act     = sel_range ? kept_r2 : kept_r1;
		violated_now = !(kept_act.upper_kept & kept_act.lower_kept);
		active       = (state_ff != SLPM_OFF) && (state_ff != SLPM_RETRACT);
	end

	assign retract_rise = failsafe_input_retract & !retract_q_ff;
	assign retract_fall = !failsafe_input_retract & retract_q_ff;

	// Enable and conflict are only re-read at power-on
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			enabled_ff               <= 1'b0;
			config_conflict_fault_ff <= 1'b0;
		end else if (power_on_pulse) begin
			enabled_ff <= safety_enable_word[`SLPM_EN_BIT];
			config_conflict_fault_ff <=
				safety_enable_word[`SLPM_EN_BIT] &
				safety_enable_word[`SLPM_SYNC_EN_BIT];
		end
	end

	// State sequencing
	always_comb begin
		nxt_state     = state_ff;
		viol_low_next = viol_low_ff;
		unique case (state_ff)
			SLPM_OFF: begin
				if (sel_fn) begin
					nxt_state = SLPM_WATCH;
				end
			end
			SLPM_WATCH: begin
				if (!sel_fn) begin
					nxt_state = SLPM_OFF;
				end else if (violated_now) begin
					nxt_state     = SLPM_VIOLATED;
					viol_low_next = !kept_act.lower_kept;
				end
			end
			SLPM_VIOLATED: begin
				// Ack is not an exit: only deselect, a referenced terminal retract edge or a clean range
				if (!sel_fn) begin
					nxt_state = SLPM_OFF;
				end else if (use_terminals && retract_rise &&
				             safely_referenced) begin
					nxt_state = SLPM_RETRACT;
				end else if (!violated_now) begin
					nxt_state = SLPM_WATCH;
				end
			end
			SLPM_RETRACT: begin
				if (retract_fall) begin
					nxt_state = sel_fn ? SLPM_WATCH : SLPM_OFF;
				end
			end
		endcase
	end

	// State register and retract edge history
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_ff     <= SLPM_OFF;
			viol_low_ff  <= 1'b0;
			retract_q_ff <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			viol_low_ff  <= viol_low_next;
			retract_q_ff <= failsafe_input_retract;
		end
	end

	// Stop request, message and bus loss reaction
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			stop_request_ff            <= 1'b0;
			stop_code_ff               <= 8'h00;
			limit_violation_message_ff <= 1'b0;
			extended_stop_retract_ff   <= 1'b0;
		end else begin
			stop_request_ff <= (nxt_state == SLPM_VIOLATED);
			stop_code_ff    <= limit_stop_response;
			// Ack while still outside only re-raises the message
			limit_violation_message_ff <= (nxt_state == SLPM_VIOLATED) |
				(safe_ack & (state_ff == SLPM_VIOLATED));
			extended_stop_retract_ff <= comm_lost & active &
				(bus_failure_delay != `SLPM_DELAY_ZERO) &
				(limit_stop_response >= `SLPM_ESR_MIN_CODE);
		end
	end

	// Direction monitor request during terminal retract
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dir_monitor_pos_ff <= 1'b0;
			dir_monitor_neg_ff <= 1'b0;
		end else begin
			dir_monitor_pos_ff <= (nxt_state == SLPM_RETRACT) &
			                      viol_low_next;
			dir_monitor_neg_ff <= (nxt_state == SLPM_RETRACT) &
			                      !viol_low_next;
		end
	end

	// Diagnostic words and telegram status words
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			control_diag_bits_ff      <= `SLPM_ZERO32;
			status_diag_bits_ff       <= `SLPM_ZERO32;
			safety_status_word_one_ff <= `SLPM_ZERO32;
			safety_status_word_two_ff <= `SLPM_ZERO32;
			failsafe_output_active_ff <= 1'b0;
			failsafe_output_area_ff   <= 1'b0;
		end else begin
			control_diag_bits_ff <= `SLPM_ZERO32;
			control_diag_bits_ff[`SLPM_CW_SEL_BIT]   <= sel_fn;
			control_diag_bits_ff[`SLPM_CW_RANGE_BIT] <= sel_range;
			status_diag_bits_ff <= `SLPM_ZERO32;
			status_diag_bits_ff[`SLPM_SW_ACTIVE_BIT] <= active;
			status_diag_bits_ff[`SLPM_SW_RANGE_BIT]  <= sel_range;
			status_diag_bits_ff[`SLPM_SW_REF_BIT] <= safely_referenced;
			status_diag_bits_ff[`SLPM_SW_UPPER_BIT] <= kept_act.upper_kept;
			status_diag_bits_ff[`SLPM_SW_LOWER_BIT] <= kept_act.lower_kept;
			safety_status_word_one_ff <= `SLPM_ZERO32;
			safety_status_word_one_ff[`SLPM_SW_ACTIVE_BIT] <=
				active & safely_referenced;
			safety_status_word_two_ff <= `SLPM_ZERO32;
			if (!short_telegram) begin
				safety_status_word_two_ff[`SLPM_SW_ACTIVE_BIT] <=
					active & safely_referenced;
				safety_status_word_two_ff[`SLPM_SW_REF_BIT] <=
					safely_referenced;
				safety_status_word_two_ff[`SLPM_SW_RANGE_BIT] <=
					sel_range;
				safety_status_word_two_ff[`SLPM_SW_UPPER_BIT] <=
					kept_act.upper_kept;
				safety_status_word_two_ff[`SLPM_SW_LOWER_BIT] <=
					kept_act.lower_kept;
			end
			failsafe_output_active_ff <= active & safely_referenced;
			failsafe_output_area_ff   <= sel_range;
		end
	end

	// Assertions
	a_stop_on_viol: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_ff == SLPM_VIOLATED) |-> stop_request_ff)
		else $error("stop not raised while violated");
	a_ack_no_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_ff == SLPM_VIOLATED && sel_fn && violated_now &&
		 !(use_terminals && retract_rise && safely_referenced))
		|=> state_ff == SLPM_VIOLATED)
		else $error("violation cleared while outside");
	a_active_and: assert property (@(posedge core_clk) disable iff (!rst_n)
		safety_status_word_one_ff[`SLPM_SW_ACTIVE_BIT] |->
		status_diag_bits_ff[`SLPM_SW_ACTIVE_BIT] &
		status_diag_bits_ff[`SLPM_SW_REF_BIT])
		else $error("reported active without referenced");
	a_conflict: assert property (@(posedge core_clk) disable iff (!rst_n)
		config_conflict_fault_ff |-> !status_diag_bits_ff[`SLPM_SW_ACTIVE_BIT])
		else $error("active despite config conflict");
	a_short_range: assert property (@(posedge core_clk) disable iff (!rst_n)
		short_telegram && !use_terminals |-> !sel_range)
		else $error("range two in short format");
	a_esr_code: assert property (@(posedge core_clk) disable iff (!rst_n)
		extended_stop_retract_ff |->
		$past(limit_stop_response) >= `SLPM_ESR_MIN_CODE)
		else $error("retract reaction with low code");
	a_retract_dir: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_ff == SLPM_RETRACT) |->
		(dir_monitor_pos_ff ^ dir_monitor_neg_ff) && !active)
		else $error("retract direction wrong");
	a_kept_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
		status_diag_bits_ff[`SLPM_SW_UPPER_BIT] ==
		safety_status_word_two_ff[`SLPM_SW_UPPER_BIT] || $past(short_telegram))
		else $error("telegram kept differs");
	a_enable_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!power_on_pulse |=> $stable(enabled_ff))
		else $error("enable changed without power-on");
	c_violation: cover property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == SLPM_WATCH ##1 state_ff == SLPM_VIOLATED);
	c_retract: cover property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == SLPM_RETRACT ##1 state_ff == SLPM_WATCH);
	c_switch: cover property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == SLPM_VIOLATED ##1 state_ff == SLPM_WATCH);
endmodule // slpm_monitor

// *** rtl/slpm_consts.svh ***
// Constants for the limited position monitor: bit positions, codes, widths.
// Included by the package and the design files; holds definitions only.
`ifndef SLPM_CONSTS_SVH
`define SLPM_CONSTS_SVH
`define SLPM_POS_W          32
`define SLPM_EN_BIT         1
`define SLPM_SYNC_EN_BIT    3
`define SLPM_CW_SEL_BIT     6
`define SLPM_CW_RANGE_BIT   19
`define SLPM_SW_ACTIVE_BIT  6
`define SLPM_SW_RANGE_BIT   19
`define SLPM_SW_REF_BIT     23
`define SLPM_SW_UPPER_BIT   30
`define SLPM_SW_LOWER_BIT   31
`define SLPM_ESR_MIN_CODE   8'h0A
`define SLPM_DELAY_ZERO     16'h0000
`define SLPM_ZERO32         32'h0000_0000
`define SLPM_ZERO16         16'h0000
`endif

// *** rtl/slpm_pkg.sv ***
// Types shared by the limited position monitor files.
// Assumes the constants header is on the include path.
`include "slpm_consts.svh"
package slpm_pkg;
	// One upper/lower limit pair
	typedef struct packed {
		logic signed [`SLPM_POS_W-1:0] upper;
		logic signed [`SLPM_POS_W-1:0] lower;
	} slpm_pair_t;
	// Comparison result of one pair
	typedef struct packed {
		logic upper_kept;
		logic lower_kept;
	} slpm_kept_t;
	// Monitor state
	typedef enum logic [1:0] {
		SLPM_OFF,
		SLPM_WATCH,
		SLPM_VIOLATED,
		SLPM_RETRACT
	} slpm_state_t;
endpackage

// *** rtl/slpm_limit_cmp.sv ***
// Registered compare of the safe position against one limit pair.
// Assumes position and limits are synchronous to core_clk.
`timescale 1ns/1ps
`include "slpm_consts.svh"
module slpm_limit_cmp
	import slpm_pkg::*;
#(
	parameter int POS_W = `SLPM_POS_W
) (
	input  wire logic                    core_clk,
	input  wire logic                    rst_n,
	input  wire logic signed [POS_W-1:0] position,
	input  wire slpm_pair_t              pair,
	output slpm_kept_t                   kept_ff
);
	// Next comparison; no hysteresis, so it may toggle at a limit
	slpm_kept_t nxt_kept;
	always_comb begin
		nxt_kept.upper_kept = !(position > pair.upper);
		nxt_kept.lower_kept = !(position < pair.lower);
	end
	// Every cycle; reset reads as both kept
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			kept_ff <= '{upper_kept: 1'b1, lower_kept: 1'b1};
		end else begin
			kept_ff <= nxt_kept;
		end
	end
endmodule // slpm_limit_cmp

// *** sim/slpm_fsc_model.sv ***
// Fail-safe controller model that builds the two safety control words.
// Assumes the bench gives its commands synchronous to core_clk.
`timescale 1ns/1ps
module slpm_fsc_model (
	input  wire logic   core_clk,
	input  wire logic   rst_n,
	input  wire logic   sel_cmd,
	input  wire logic   range_cmd,
	output logic [31:0] safety_control_word_one,
	output logic [31:0] safety_control_word_two
);
	// Words are refreshed each cycle, as a telegram would be
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			safety_control_word_one <= 32'h0000_0000;
			safety_control_word_two <= 32'h0000_0000;
		end else begin
			// Select rides in both words so either copy is enough
			safety_control_word_one <= {25'h0, sel_cmd, 6'h00};
			safety_control_word_two <= {12'h0, range_cmd, 12'h0,
				sel_cmd, 6'h00};
		end
	end
endmodule // slpm_fsc_model

// *** sim/test_slpm_monitor.sv ***
// Self-checking bench for the limited position monitor.
// Assumes the controller model drives the control words.
`timescale 1ns/1ps
module test_slpm_monitor;
	import slpm_pkg::*;
	logic core_clk, rst_n, pwr, sel, rng, ack, lost, refd, shrt;
	logic [31:0] en_word, cdiag, sdiag, sw1, sw2, w1, w2;
	logic signed [31:0] pos;
	logic [7:0] code, scode;
	logic [15:0] dly;
	slpm_pair_t up_pair, lo_pair;
	logic fo_act, fo_area, stop, extended_stop_retract, msg, cfgf, dpos, dneg;
	logic term, fsel, frng, fret;
	int error_cnt, checked;
	// Range one spans -1000..1000, range two spans 2000..5000
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	slpm_fsc_model fsc (.core_clk(core_clk), .rst_n(rst_n), .sel_cmd(sel),
		.range_cmd(rng), .safety_control_word_one(w1),
		.safety_control_word_two(w2));
	slpm_monitor DUT (.core_clk(core_clk), .rst_n(rst_n),
		.power_on_pulse(pwr), .safety_enable_word(en_word),
		.upper_limit_pair(up_pair), .lower_limit_pair(lo_pair),
		.limit_stop_response(code), .bus_failure_delay(dly),
		.use_terminals(term), .short_telegram(shrt),
		.safety_control_word_one(w1), .safety_control_word_two(w2),
		.failsafe_input_select(fsel), .failsafe_input_range(frng),
		.failsafe_input_retract(fret), .safe_ack(ack), .comm_lost(lost),
		.safely_referenced(refd), .position(pos),
		.control_diag_bits_ff(cdiag), .status_diag_bits_ff(sdiag),
		.safety_status_word_one_ff(sw1), .safety_status_word_two_ff(sw2),
		.failsafe_output_active_ff(fo_act),
		.failsafe_output_area_ff(fo_area), .stop_request_ff(stop),
		.stop_code_ff(scode), .extended_stop_retract_ff(extended_stop_retract),
		.limit_violation_message_ff(msg), .config_conflict_fault_ff(cfgf),
		.dir_monitor_pos_ff(dpos), .dir_monitor_neg_ff(dneg));
	// Whole clock cycles; four covers model plus design latency
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Bounded wait for the stop request to reach a level
	task automatic wait_stop(input logic lvl);
		int i;
		for (i = 0; i < 20 && stop !== lvl; i++) cyc(1);
		if (stop !== lvl) begin
			error_cnt++;
			summarize();
		end
	endtask
	task automatic power_on(input logic [31:0] w);
		en_word <= w;
		pwr <= 1'b1;
		cyc(1);
		pwr <= 1'b0;
		cyc(4);
	endtask
	// Selection refused before enable and under a conflict
	task automatic t_enable();
		sel <= 1'b1;
		cyc(4);
		chk(sdiag[6], 1'b0);
		power_on(32'h0000_000A);
		chk(cfgf, 1'b1);
		chk(sdiag[6], 1'b0);
		power_on(32'h0000_0002);
		chk(cfgf, 1'b0);
		chk(sdiag[6], 1'b1);
		$display("test enable done");
	endtask
	// On the limit is still kept; active output needs referencing
	task automatic t_inside();
		pos <= 32'h0000_03E8;
		cyc(4);
		chk(cdiag[6], 1'b1);
		chk(sdiag[31:30], 2'h3);
		chk(sw2[31:30], 2'h3);
		chk({sw1[6], sw2[6], sw2[23], fo_act}, 4'hF);
		chk(stop, 1'b0);
		refd <= 1'b0;
		cyc(4);
		chk({sw1[6], sw2[23], fo_act}, 3'h0);
		refd <= 1'b1;
		cyc(4);
		$display("test inside done");
	endtask
	// One past the limit stops; ack alone never clears it
	task automatic t_violate();
		pos <= 32'h0000_03E9;
		wait_stop(1'b1);
		chk({msg, scode}, {1'b1, code});
		chk(sdiag[31:30], 2'h2);
		ack <= 1'b1;
		cyc(1);
		ack <= 1'b0;
		cyc(4);
		chk({stop, msg}, 2'h3);
		pos <= 32'h0000_0BB8;
		rng <= 1'b1;
		wait_stop(1'b0);
		chk({cdiag[19], sdiag[19], sw2[19], fo_area}, 4'hF);
		chk(msg, 1'b0);
		pos <= 32'h0000_03E9;
		wait_stop(1'b1);
		chk(sdiag[31:30], 2'h1);
		sel <= 1'b0;
		wait_stop(1'b0);
		chk(msg, 1'b0);
		// Controller retract: ack, move back, reselect, wait active
		ack <= 1'b1;
		pos <= 32'h0000_0BB8;
		cyc(1);
		ack <= 1'b0;
		sel <= 1'b1;
		cyc(4);
		chk({sdiag[6], stop}, 2'h2);
		$display("test violate done");
	endtask
	// Bus loss retract only with delay set and code of at least 10
	task automatic t_bus_loss();
		sel <= 1'b1;
		rng <= 1'b0;
		pos <= 32'h0000_0000;
		dly <= 16'h0001;
		lost <= 1'b1;
		code <= 8'h0A;
		cyc(4);
		chk(extended_stop_retract, 1'b1);
		code <= 8'h09;
		cyc(4);
		chk(extended_stop_retract, 1'b0);
		code <= 8'h0A;
		dly <= 16'h0000;
		cyc(4);
		chk(extended_stop_retract, 1'b0);
		lost <= 1'b0;
		$display("test bus loss done");
	endtask
	// Short format: range two refused, word two feedback empty
	task automatic t_short();
		shrt <= 1'b1;
		rng <= 1'b1;
		cyc(4);
		chk(sw2, 32'h0000_0000);
		chk(sdiag[19], 1'b0);
		$display("test short done");
	endtask
	// Terminal control: retract edge swaps limiting for direction monitor
	task automatic t_terminal();
		{term, fsel, frng, shrt} <= 4'hC;
		pos <= 32'hFFFF_FC17;
		wait_stop(1'b1);
		chk({fo_act, fo_area, msg}, 3'h5);
		fret <= 1'b1;
		cyc(3);
		chk({dpos, dneg, stop, sdiag[6]}, 4'h8);
		ack <= 1'b1;
		pos <= 32'h0000_0000;
		cyc(1);
		ack <= 1'b0;
		fret <= 1'b0;
		cyc(4);
		chk({dpos, dneg, stop, sdiag[6], fo_act}, 5'h03);
		// Move into range two first so the switch never sees a breach
		pos <= 32'h0000_0BB8;
		cyc(1);
		frng <= 1'b1;
		cyc(4);
		chk({fo_area, sdiag[19], stop}, 3'h6);
		$display("test terminal done");
	endtask
	// Inputs quiet at time zero, reset three cycles
	initial begin
		error_cnt = 0;
		checked = 0;
		rst_n = 1'b0;
		{pwr, sel, rng, ack, lost, shrt, term, fsel, frng, fret} = 10'h000;
		refd = 1'b1;
		en_word = 32'h0000_0000;
		pos = 32'h0000_0000;
		code = 8'h03;
		dly = 16'h0000;
		up_pair = {32'h0000_03E8, 32'h0000_1388};
		lo_pair = {32'hFFFF_FC18, 32'h0000_07D0};
		cyc(3);
		rst_n <= 1'b1;
		t_enable();
		t_inside();
		t_violate();
		t_bus_loss();
		t_short();
		t_terminal();
		summarize();
	end
endmodule // test_slpm_monitor
